// ===== verilog/ssr_pkg.sv
// constants, types and record layout for the state group reader
// assumes a byte stream transport around it and one sys_clk domain
package ssr_pkg;

  // ************************************************************
  // request and response framing
  // ************************************************************
  localparam int          REQ_BYTES         = 4;      // handle lo, handle hi, mask, reserved
  localparam logic [1:0]  REQ_IDX_HANDLE_LO = 2'h0;
  localparam logic [1:0]  REQ_IDX_HANDLE_HI = 2'h1;
  localparam logic [1:0]  REQ_IDX_MASK      = 2'h2;
  localparam logic [1:0]  REQ_IDX_LAST      = 2'h3;   // reserved byte, ignored
  localparam logic [1:0]  REC_IDX_OP        = 2'h0;
  localparam logic [1:0]  REC_IDX_CUR       = 2'h1;
  localparam logic [1:0]  REC_IDX_PRIOR     = 2'h2;
  localparam logic [1:0]  REC_IDX_LAST      = 2'h3;   // last event state
  localparam int          MAX_SETS          = 8;
  localparam logic [3:0]  SET_COUNT_MIN     = 4'h1;
  localparam logic [3:0]  SET_COUNT_MAX     = 4'h8;
  localparam logic [2:0]  SET_IDX_MAX       = 3'h7;
  localparam int          FIFO_DEPTH        = 8;
  localparam int          BYTE_W            = 8;

  // ************************************************************
  // result codes and reserved handles
  // ************************************************************
  localparam logic [7:0]  RESULT_SUCCESS        = 8'h00;
  localparam logic [7:0]  UNKNOWN_HANDLE_ERROR  = 8'h80;
  localparam logic [15:0] HANDLE_RSVD_LO        = 16'h0000;
  localparam logic [15:0] HANDLE_RSVD_HI        = 16'hffff;
  localparam logic [7:0]  STATE_RESET           = 8'h00;

  // responder sequencing
  typedef enum logic [1:0] {
    ST_REQ,
    ST_STATUS,
    ST_COUNT,
    ST_RECORD
  } ssr_state_e;

  // one per-sensor state record, sent in field order
  typedef struct packed {
    logic [7:0] operational_condition;
    logic [7:0] current_state;
    logic [7:0] prior_state;
    logic [7:0] last_event_state;
  } ssr_record_s;

endpackage

// ===== verilog/ssr_fifo.sv
// small flip-flop fifo with valid/ready on both sides
// assumes both sides on sys_clk; rst is synchronous, active high
`timescale 1ns/1ns
module ssr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      fill_reg;
  logic             push;
  logic             pop;

  // ************************************************************
  // flags and handshakes
  // ************************************************************
  assign in_ready  = (fill_reg != (AW+1)'(DEPTH));
  assign out_valid = (fill_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];   // storage is flops

  // storage write, no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers wrap at depth; depth is a power of two
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fill_reg   <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop) fill_reg <= fill_reg + 1'b1;
      else if (pop && !push) fill_reg <= fill_reg - 1'b1;
    end
  end

endmodule // ssr_fifo

// ===== verilog/ssr_reader.sv
// responder for the read state group command: parses a 4-byte request,
// streams result status, set count and the state records through a fifo
// assumes request bytes and sensor inputs come from logic on sys_clk
`timescale 1ns/1ns

// Function
// - one handle groups several sensors; one request returns all their readings
// - response carries one to eight state records back to back
// - records go out in ascending sensor offset order from offset 0
// - record count and order per handle never depend on sensor condition
// - handles 0x0000 and 0xffff are reserved, never assigned nor used
// - rearm mask bit n maps to sensor at offset n
// - mask bits below the set count rearm their sensor when one
// - response opens with result status; 0x80 marks unknown handle
// - set count byte follows status, value 1 through 8
// - exactly set count records follow the count byte
// - each record reports operational condition, current and event state
// - record is operational, current, prior, last event bytes in order
// - prior state updates when a new assessment differs from current
// - unknown prior state is reported equal to current state
// - last event state holds newest assessed state that raised an event
module ssr_reader (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [15:0]          cfg_handle,
  input  wire logic [3:0]           cfg_set_count,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic [7:0]           req_data,
  output logic                      rsp_valid,
  input  wire logic                 rsp_ready,
  output logic      [7:0]           rsp_data,
  input  wire logic [7:0][7:0]      sense_op,
  input  wire logic [7:0]           sense_valid,
  input  wire logic [7:0][7:0]      sense_state,
  input  wire logic [7:0]           sense_event,
  input  wire logic [7:0]           sensor_init,
  output logic      [7:0]           rearm_pulse,
  output logic                      busy
);

  ssr_pkg::ssr_state_e  state_reg;
  ssr_pkg::ssr_state_e  state_next;
  ssr_pkg::ssr_record_s rec_reg [ssr_pkg::MAX_SETS];
  logic [7:0]           known_reg;
  logic [1:0]           req_idx_reg;
  logic [7:0]           handle_lo_reg;
  logic [7:0]           mask_reg;
  logic                 match_reg;
  logic [3:0]           resp_count_reg;
  logic [2:0]           set_idx_reg;
  logic [1:0]           byte_idx_reg;
  logic [7:0]           rearm_pulse_reg;
  logic                 fifo_ready;
  logic                 fifo_valid;
  logic [7:0]           fifo_byte;
  logic                 push_ok;
  logic                 req_take;
  logic                 req_done;
  logic [15:0]          req_handle;
  logic                 handle_legal;
  logic                 handle_match;
  logic [3:0]           eff_count;
  logic [8:0]           count_onehot;
  logic [8:0]           count_mask9;
  logic [7:0]           count_mask;
  logic [2:0]           last_set;
  logic                 rec_last;
  ssr_pkg::ssr_record_s cur_rec;
  logic [7:0]           rec_byte;

  // ************************************************************
  // request decode
  // ************************************************************
  // the set count is clamped so a bad strap never breaks framing
  assign eff_count    = (cfg_set_count < ssr_pkg::SET_COUNT_MIN) ? ssr_pkg::SET_COUNT_MIN :
                        (cfg_set_count > ssr_pkg::SET_COUNT_MAX) ? ssr_pkg::SET_COUNT_MAX :
                        cfg_set_count;
  assign count_onehot = 9'h001 << eff_count;
  assign count_mask9  = count_onehot - 9'h001;
  assign count_mask   = count_mask9[7:0];
  assign req_ready    = (state_reg == ssr_pkg::ST_REQ);
  assign req_take     = req_valid & req_ready;
  assign req_done     = req_take & (req_idx_reg == ssr_pkg::REQ_IDX_LAST);
  assign req_handle   = {req_data, handle_lo_reg};
  // a reserved handle is never ours, even if strapped that way
  assign handle_legal = (cfg_handle != ssr_pkg::HANDLE_RSVD_LO) &&
                        (cfg_handle != ssr_pkg::HANDLE_RSVD_HI);
  assign handle_match = handle_legal && (req_handle == cfg_handle);

  // request byte capture; reserved byte is accepted and dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_idx_reg   <= 2'h0;
      handle_lo_reg <= 8'h00;
      mask_reg      <= 8'h00;
      match_reg     <= 1'b0;
    end else if (req_take) begin
      req_idx_reg <= req_idx_reg + 2'h1;
      if (req_idx_reg == ssr_pkg::REQ_IDX_HANDLE_LO) handle_lo_reg <= req_data;
      if (req_idx_reg == ssr_pkg::REQ_IDX_HANDLE_HI) match_reg <= handle_match;
      if (req_idx_reg == ssr_pkg::REQ_IDX_MASK)      mask_reg  <= req_data;
    end
  end

  // rearm is one pulse per accepted request to our handle, masked to the live sets
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rearm_pulse_reg <= 8'h00;
    end else if (req_done && match_reg) begin
      rearm_pulse_reg <= mask_reg & count_mask;
    end else begin
      rearm_pulse_reg <= 8'h00;
    end
  end
  assign rearm_pulse = rearm_pulse_reg;

  // ************************************************************
  // per-sensor state tracking
  // ************************************************************
  generate
    for (genvar i = 0; i < ssr_pkg::MAX_SETS; i++) begin : g_sensor
      // prior takes current on a real change of assessed state and on sensor init
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          rec_reg[i]   <= '{default: ssr_pkg::STATE_RESET};
          known_reg[i] <= 1'b0;
        end else begin
          rec_reg[i].operational_condition <= sense_op[i];
          if (sensor_init[i]) begin
            known_reg[i]           <= 1'b0;
            rec_reg[i].prior_state <= rec_reg[i].current_state;
          end else if (sense_valid[i]) begin
            known_reg[i]             <= 1'b1;
            rec_reg[i].current_state <= sense_state[i];
            if (!known_reg[i]) begin
              rec_reg[i].prior_state <= sense_state[i];
            end else if (sense_state[i] != rec_reg[i].current_state) begin
              rec_reg[i].prior_state <= rec_reg[i].current_state;
            end
          end
          // a sample dropped by a same-cycle init must not leave an event behind
          if (sense_valid[i] && sense_event[i] && !sensor_init[i]) begin
            rec_reg[i].last_event_state <= sense_state[i];
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // response sequencing
  // ************************************************************
  assign last_set = resp_count_reg[2:0] - 3'h1;
  assign rec_last = (set_idx_reg == last_set) && (byte_idx_reg == ssr_pkg::REC_IDX_LAST);
  assign cur_rec  = rec_reg[set_idx_reg];
  assign rec_byte = (byte_idx_reg == ssr_pkg::REC_IDX_OP)    ? cur_rec.operational_condition :
                    (byte_idx_reg == ssr_pkg::REC_IDX_CUR)   ? cur_rec.current_state :
                    (byte_idx_reg == ssr_pkg::REC_IDX_PRIOR) ? cur_rec.prior_state :
                    cur_rec.last_event_state;
  assign push_ok  = fifo_valid & fifo_ready;

  // byte offered to the fifo in each response state
  always_comb begin
    fifo_valid = 1'b1;
    fifo_byte  = 8'h00;
    state_next = state_reg;
    case (state_reg)
      ssr_pkg::ST_REQ: begin
        fifo_valid = 1'b0;
        if (req_done) state_next = ssr_pkg::ST_STATUS;
      end
      ssr_pkg::ST_STATUS: begin
        fifo_byte = match_reg ? ssr_pkg::RESULT_SUCCESS
                              : ssr_pkg::UNKNOWN_HANDLE_ERROR;
        if (fifo_ready) state_next = match_reg ? ssr_pkg::ST_COUNT : ssr_pkg::ST_REQ;
      end
      ssr_pkg::ST_COUNT: begin
        fifo_byte = {4'h0, resp_count_reg};
        if (fifo_ready) state_next = ssr_pkg::ST_RECORD;
      end
      ssr_pkg::ST_RECORD: begin
        fifo_byte = rec_byte;
        if (fifo_ready && rec_last) state_next = ssr_pkg::ST_REQ;
      end
      default: begin
        fifo_valid = 1'b0;
        state_next = ssr_pkg::ST_REQ;
      end
    endcase
  end

  // count is frozen per response so framing never changes mid-stream
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg      <= ssr_pkg::ST_REQ;
      resp_count_reg <= ssr_pkg::SET_COUNT_MIN;
      set_idx_reg    <= 3'h0;
      byte_idx_reg   <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (req_done) begin
        resp_count_reg <= eff_count;
        set_idx_reg    <= 3'h0;
        byte_idx_reg   <= 2'h0;
      end else if (state_reg == ssr_pkg::ST_RECORD && push_ok) begin
        byte_idx_reg <= byte_idx_reg + 2'h1;
        if (byte_idx_reg == ssr_pkg::REC_IDX_LAST) set_idx_reg <= set_idx_reg + 3'h1;
      end
    end
  end

  assign busy = (state_reg != ssr_pkg::ST_REQ);

  // ************************************************************
  // response buffer
  // ************************************************************
  // a stalled drain side backs up into the sequencer, never drops bytes
  ssr_fifo #(
    .WIDTH (ssr_pkg::BYTE_W),
    .DEPTH (ssr_pkg::FIFO_DEPTH)
  ) u_rsp_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (fifo_valid),
    .in_ready  (fifo_ready),
    .in_data   (fifo_byte),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp_data)
  );

endmodule // ssr_reader

// ===== testbench/ssr_reader_assertions.sv
// checker for the state group reader, watching its ports only
// assumes one sys_clk domain and rst synchronous, active high
`timescale 1ns/1ns
module ssr_reader_assertions (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [15:0] cfg_handle,
  input wire logic [3:0]  cfg_set_count,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [7:0]  req_data,
  input wire logic        rsp_valid,
  input wire logic        rsp_ready,
  input wire logic [7:0]  rsp_data,
  input wire logic [7:0]  rearm_pulse,
  input wire logic        busy
);
  // ************************************************************
  // request tracking
  // ************************************************************
  logic [1:0]  idx_reg;
  logic [15:0] hnd_reg;
  logic [7:0]  msk_reg;
  wire         take = req_valid && req_ready;
  wire         last_take = take && (idx_reg == 2'h3);
  wire  [3:0]  cnt = (cfg_set_count == 4'h0) ? 4'h1 :
                     (cfg_set_count > 4'h8) ? 4'h8 : cfg_set_count;
  wire  [7:0]  low = 8'((9'h1 << cnt) - 9'h1);
  // reserved handles never match, whatever the configuration says
  wire         hit = (hnd_reg == cfg_handle) && (cfg_handle != 16'h0000) &&
                     (cfg_handle != 16'hffff);
  // byte index wraps every four accepted bytes
  always_ff @(posedge sys_clk) begin
    if (rst) idx_reg <= 2'h0;
    else if (take) idx_reg <= idx_reg + 2'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (take && idx_reg == 2'h0) hnd_reg[7:0] <= req_data;
    if (take && idx_reg == 2'h1) hnd_reg[15:8] <= req_data;
    if (take && idx_reg == 2'h2) msk_reg <= req_data;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_last; last_take; endsequence
  sequence s_status_out; ##2 rsp_valid; endsequence
  sequence s_locked; ##1 (busy && !req_ready); endsequence
  AST_REARM_HIT: assert property (s_last and hit |=> rearm_pulse == (msk_reg & low))
    else $error("rearm pulse does not match mask");
  AST_REARM_MISS: assert property (s_last and !hit |=> rearm_pulse == 8'h00)
    else $error("rearm pulse on unknown handle");
  AST_REARM_CAUSE: assert property (rearm_pulse != 8'h00 |-> $past(last_take))
    else $error("rearm pulse without request");
  AST_REARM_PULSE: assert property (rearm_pulse != 8'h00 |=> rearm_pulse == 8'h00)
    else $error("rearm pulse longer than one cycle");
  AST_HI_BITS: assert property ((rearm_pulse & ~low) == 8'h00)
    else $error("rearm beyond set count");
  AST_ANSWER: assert property (s_last |-> s_status_out)
    else $error("no response two cycles after request");
  AST_LOCK: assert property (s_last |-> s_locked)
    else $error("request port not locked while answering");
  AST_READY: assert property (req_ready == !busy)
    else $error("ready and busy disagree");
  AST_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("response byte lost while stalled");
endmodule // ssr_reader_assertions

bind ssr_reader ssr_reader_assertions u_chk (.sys_clk(sys_clk), .rst(rst),
  .cfg_handle(cfg_handle), .cfg_set_count(cfg_set_count), .req_valid(req_valid),
  .req_ready(req_ready), .req_data(req_data), .rsp_valid(rsp_valid),
  .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rearm_pulse(rearm_pulse), .busy(busy));

// ===== testbench/ssr_ctrl_model.sv
// management controller model: sends requests, drains response bytes
// assumes sys_clk domain; stall from the bench holds off draining
`timescale 1ns/1ns
module ssr_ctrl_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  output logic            req_valid,
  input  wire logic       req_ready,
  output logic [7:0]      req_data,
  input  wire logic       rsp_valid,
  output logic            rsp_ready,
  input  wire logic [7:0] rsp_data,
  input  wire logic       stall
);
  logic [7:0] rx [$];
  initial begin
    req_valid = 1'b0;
    req_data = 8'h00;
    rsp_ready = 1'b0;
  end
  // drain side: capture at the accepting edge, ready follows stall
  always @(posedge sys_clk) begin
    if (rsp_valid && rsp_ready) rx.push_back(rsp_data);
    rsp_ready <= !stall && !rst;
  end
  // handle is whatever the bench commands, reserved ones only on purpose
  task send(input logic [15:0] h, input logic [7:0] m);
    logic [7:0] b [4];
    b = '{h[7:0], h[15:8], m, 8'h00}; // handle low, high, mask, zero
    @(posedge sys_clk);
    foreach (b[i]) begin
      req_valid <= 1'b1;
      req_data <= b[i];
      do @(posedge sys_clk); while (!req_ready);
    end
    req_valid <= 1'b0;
    req_data <= ~b[3]; // released bus shows no stale byte
  endtask
endmodule // ssr_ctrl_model

// ===== testbench/tb_top.sv
// self-checking bench for the state group reader
// assumes a 100 MHz sys_clk and the controller model beside the design
`timescale 1ns/1ns
module tb_top;
  logic            sys_clk, rst, stall, req_valid, req_ready, rsp_valid, rsp_ready, busy;
  logic [15:0]     cfg_handle;
  logic [3:0]      cfg_set_count;
  logic [7:0]      req_data, rsp_data, sense_valid, sense_event, sensor_init, rearm_pulse;
  logic [7:0][7:0] sense_op, sense_state;
  logic [7:0]      cur [8], pri [8], evs [8];
  bit              unk [8];
  logic [7:0]      rearm_seen;
  int              err_count, n_checks, cyc;
  ssr_reader DUT (.sys_clk, .rst, .cfg_handle, .cfg_set_count, .req_valid, .req_ready,
    .req_data, .rsp_valid, .rsp_ready, .rsp_data, .sense_op, .sense_valid, .sense_state,
    .sense_event, .sensor_init, .rearm_pulse, .busy);
  ssr_ctrl_model m_ctrl (.sys_clk, .rst, .req_valid, .req_ready, .req_data, .rsp_valid,
    .rsp_ready, .rsp_data, .stall);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ************************************************************
  // tasks
  // ************************************************************
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one assessment pulse; the bench keeps its own copy of each record
  task assess(input int i, input logic [7:0] st, input logic ev);
    @(posedge sys_clk);
    sense_valid[i] <= 1'b1;
    sense_state[i] <= st;
    sense_event[i] <= ev;
    @(posedge sys_clk);
    sense_valid[i] <= 1'b0;
    sense_state[i] <= ~st;
    if (unk[i]) pri[i] = st;
    else if (st != cur[i]) pri[i] = cur[i];
    unk[i] = 1'b0;
    cur[i] = st;
    if (ev) evs[i] = st;
  endtask
  task reinit(input int i);
    @(posedge sys_clk);
    sensor_init[i] <= 1'b1;
    @(posedge sys_clk);
    sensor_init[i] <= 1'b0;
    pri[i] = cur[i];
    unk[i] = 1'b1;
  endtask
  // n records expected; n of zero means only the unknown handle status
  task run_req(input logic [15:0] h, input logic [7:0] m, input int n);
    logic [7:0] e [$];
    int k;
    // let pending stimulus settle before the expectation reads it
    @(posedge sys_clk);
    e = {};
    if (n == 0) e.push_back(8'h80);
    else begin
      e.push_back(8'h00);
      e.push_back(8'(n));
      for (int i = 0; i < n; i++) e = {e, sense_op[i], cur[i], pri[i], evs[i]};
    end
    m_ctrl.rx.delete();
    rearm_seen = 8'h00;
    m_ctrl.send(h, m);
    for (k = 0; k < 300 && m_ctrl.rx.size() < e.size(); k++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    chk(8'(m_ctrl.rx.size()), 8'(e.size()));
    foreach (e[j]) chk(m_ctrl.rx[j], e[j]);
    chk(rearm_seen, m & 8'((9'h1 << n) - 9'h1));
  endtask
  // collect every rearm bit raised during one request
  always @(posedge sys_clk) begin
    if (rearm_pulse != 8'h00) rearm_seen <= rearm_seen | rearm_pulse;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    stall = 1'b0;
    cfg_handle = 16'h1234;
    cfg_set_count = 4'h8;
    {sense_valid, sense_event, sensor_init} = '0;
    sense_op = '0;
    sense_state = '0;
    foreach (cur[i]) {cur[i], pri[i], evs[i], unk[i]} = {24'h0, 1'b1};
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      sense_op[i] <= 8'hc0 + 8'(i);
      assess(i, 8'h10 + 8'(i), i[0]);
    end
    assess(2, 8'h33, 1'b1);
    assess(2, 8'h33, 1'b0);
    reinit(5);
    stall <= 1'b1;
    fork
      run_req(16'h1234, 8'ha5, 8);
      begin
        repeat (20) @(posedge sys_clk);
        stall <= 1'b0;
      end
    join
    assess(5, 8'h55, 1'b0);
    sense_op[0] <= 8'h01;
    cfg_set_count <= 4'h1;
    run_req(16'h1234, 8'hff, 1);
    cfg_set_count <= 4'h3;
    run_req(16'h1234, 8'hfe, 3);
    cfg_set_count <= 4'h0;
    run_req(16'h1234, 8'h03, 1);
    cfg_set_count <= 4'hf;
    run_req(16'h1234, 8'h81, 8);
    run_req(16'h1235, 8'hff, 0);
    cfg_handle <= 16'hffff;
    run_req(16'hffff, 8'hff, 0);
    cfg_handle <= 16'h0000;
    run_req(16'h0000, 8'hff, 0);
    print_verdict();
  end
endmodule // tb_top
